// ### core/ucf_pkg.sv
// constants, state codes and helpers of the serial clock and frame block
package ucf_pkg;
  localparam int DIV_W = 12;
  localparam int ADDR_W = 8;

  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CTRL_C = 8'h08;
  localparam logic [7:0] OFS_BAUD_LO = 8'h0c;
  localparam logic [7:0] OFS_BAUD_HI = 8'h10;
  localparam logic [7:0] OFS_TX_DATA = 8'h14;
  localparam logic [7:0] OFS_RX_DATA = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  localparam int A_DSPEED = 1;
  localparam int B_NINTH = 0;
  localparam int B_CSZ2 = 2;
  localparam int B_PINDIR = 7;
  localparam int C_POL = 0;
  localparam int C_CSZ_LO = 1;
  localparam int C_STOP = 3;
  localparam int C_PAR_LO = 4;
  localparam int C_SYNC = 6;

  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] CTRL_C_RST = 8'h06;
  localparam logic [11:0] BAUD_RST = 12'h000;

  localparam logic [4:0] OS_NORMAL = 5'h10;
  localparam logic [4:0] OS_DOUBLE = 5'h08;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    TX_IDLE = 6'h01,
    TX_START = 6'h02,
    TX_DATA = 6'h04,
    TX_PAR = 6'h08,
    TX_STOP1 = 6'h10,
    TX_STOP2 = 6'h20
  } ucf_tx_e;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_STOP = 5'h10
  } ucf_rx_e;

  // data bits per character; 4 to 6 are reserved and give 8
  function automatic logic [3:0] char_bits(input logic [2:0] csz);
    case (csz)
      3'h0: return 4'h5;
      3'h1: return 4'h6;
      3'h2: return 4'h7;
      3'h7: return 4'h9;
      default: return 4'h8;
    endcase
  endfunction

  // xor of the low n data bits, inverted for odd parity
  function automatic logic par_bit(input logic [8:0] d, input logic [3:0] n, input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) begin
        p = p ^ d[i];
      end
    end
    return p;
  endfunction
endpackage

// ### core/ucf_clk_if.sv
// clock generation signals shared between the core and its helpers
`timescale 1ns/1ps
interface ucf_clk_if;
  logic [ucf_pkg::DIV_W-1:0] divisor;
  logic reload;
  logic tick;
  logic xck_pin;
  logic xck_rise;
  logic xck_fall;
  modport baud (input divisor, input reload, output tick);
  modport sync (input xck_pin, output xck_rise, output xck_fall);
  modport core (output divisor, output reload, input tick, output xck_pin,
    input xck_rise, input xck_fall);
endinterface

// ### core/ucf_baud_gen.sv
// reloadable baud down-counter producing one tick per zero
`timescale 1ns/1ps
module ucf_baud_gen (
  input wire logic aclk,
  input wire logic aresetn,
  ucf_clk_if.baud bif
);
  logic [ucf_pkg::DIV_W-1:0] cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= ucf_pkg::BAUD_RST;
    end else if (bif.reload || cnt == '0) begin
      cnt <= bif.divisor;
    end else begin
      cnt <= cnt - 1'b1;
    end
  end

  assign bif.tick = (cnt == '0);

  property p_reload_zero;
    @(posedge aclk) disable iff (!aresetn)
    (cnt == '0 && !bif.reload) |=> cnt == $past(bif.divisor);
  endproperty
  a_reload_zero: assert property (p_reload_zero) else $error("no reload at zero");

  property p_reload_write;
    @(posedge aclk) disable iff (!aresetn)
    bif.reload |=> (cnt == $past(bif.divisor)) && (bif.tick == ($past(bif.divisor) == '0))
      ##0 $stable(bif.divisor);
  endproperty
  a_reload_write: assert property (p_reload_write) else $error("no reload on low write");

  property p_tick_period;
    @(posedge aclk) disable iff (!aresetn)
    (bif.tick && bif.divisor == 12'h001 && !bif.reload) ##1 (!bif.reload && bif.divisor == 12'h001)
      |-> !bif.tick ##1 bif.tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick rate wrong");
endmodule

// ### core/ucf_xck_sync.sv
// synchroniser and edge detector for the external transfer clock
`timescale 1ns/1ps
module ucf_xck_sync (
  input wire logic aclk,
  input wire logic aresetn,
  ucf_clk_if.sync bif
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= bif.xck_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign bif.xck_rise = s2 & ~s3;
  assign bif.xck_fall = ~s2 & s3;

  property p_rise_delay;
    @(posedge aclk) disable iff (!aresetn)
    ($rose(bif.xck_pin) ##1 bif.xck_pin) |=> bif.xck_rise;
  endproperty
  a_rise_delay: assert property (p_rise_delay) else $error("rise edge not two cycles late");

  property p_fall_delay;
    @(posedge aclk) disable iff (!aresetn)
    ($fell(bif.xck_pin) ##1 !bif.xck_pin) |=> bif.xck_fall;
  endproperty
  a_fall_delay: assert property (p_fall_delay) else $error("fall edge not two cycles late");
endmodule

// ### core/ucf_top.sv
// serial clock generation and frame formatter behind an axi4-lite slave
`timescale 1ns/1ps
// Contract
// - sync select picks async or sync clocking
// - in sync, pin direction picks master or slave
// - clock pin used only in sync mode
// - baud counter reloads at zero and low write
// - one tick per counter zero
// - baud divisor is twelve bits wide
// - transmit divides ticks by 16, 8 or 2
// - receiver uses undivided ticks, 16/8/2 states
// - double speed only in async, halves divisor
// - slave clock synchronised, edge detected, two cycles
// - sample on edge opposite to data change
// - polarity picks change and sample edges
// - 5 to 9 bits, parity, one/two stops
// - start, data lsb first, parity, stops
// - start low, stop high, idle high
// - format change aborts both directions
// - size, parity and stop fields set format
// - only first stop checked for frame error
// - parity is xor, inverted for odd
// - size seven gives nine bits, ninth bit
module ucf_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ucf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ucf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic txd,
  input wire logic rxd,
  input wire logic sync_clock_pin_i,
  output logic sync_clock_pin_o,
  output logic sync_clock_pin_oe
);
  ucf_clk_if bif ();

  logic [7:0] ctrl_status_a;
  logic [7:0] ctrl_status_b;
  logic [7:0] ctrl_status_c;
  logic [ucf_pkg::DIV_W-1:0] baud_divisor;
  logic aw_held;
  logic w_held;
  logic [ucf_pkg::ADDR_W-1:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic do_wr;
  logic wr_lane;
  logic next_aw_held;
  logic next_w_held;
  logic next_rvalid;
  logic rd_take;
  logic rd_rx;
  logic [31:0] rd_word;
  logic rd_ok;
  logic reload;
  logic fmt_change;
  logic sync_mode_select;
  logic master;
  logic dbl;
  logic [3:0] nbits;
  logic par_en;
  logic par_odd;
  logic pol;
  logic [4:0] os_div;
  logic [3:0] os_last;
  logic [3:0] os_half;
  logic ck_rise;
  logic ck_fall;
  logic chg_edge;
  logic smp_edge;
  logic [3:0] tx_pre;
  logic tx_bit;
  logic tx_load;
  logic [8:0] tx_word;
  ucf_pkg::ucf_tx_e tx_state;
  logic [8:0] tx_sh;
  logic [3:0] tx_cnt;
  logic tx_par;
  logic exp_par;
  logic rx_s1;
  logic rx_s2;
  ucf_pkg::ucf_rx_e rx_state;
  logic [3:0] rx_os;
  logic [3:0] rx_cnt;
  logic [8:0] rx_sh;
  logic rx_acc;
  logic rx_step;
  logic rx_mid;
  logic rx_fin;
  logic [8:0] rx_data;
  logic rx_done;
  logic frame_error_flag;
  logic parity_error;

  function automatic logic addr_ok(input logic [ucf_pkg::ADDR_W-1:0] a);
    return a == ucf_pkg::OFS_CTRL_A || a == ucf_pkg::OFS_CTRL_B || a == ucf_pkg::OFS_CTRL_C
      || a == ucf_pkg::OFS_BAUD_LO || a == ucf_pkg::OFS_BAUD_HI || a == ucf_pkg::OFS_TX_DATA
      || a == ucf_pkg::OFS_RX_DATA || a == ucf_pkg::OFS_STATUS;
  endfunction

  ucf_baud_gen u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .bif(bif)
  );

  ucf_xck_sync u_xck (
    .aclk(aclk),
    .aresetn(aresetn),
    .bif(bif)
  );

  // axi4-lite write channel
  assign do_wr = aw_held && w_held && !s_axi_bvalid;
  assign wr_lane = do_wr && ws_q[0];
  assign next_aw_held = (aw_held || (s_axi_awvalid && s_axi_awready)) && !do_wr;
  assign next_w_held = (w_held || (s_axi_wvalid && s_axi_wready)) && !do_wr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= '0;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ucf_pkg::RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_awready <= !next_aw_held;
      s_axi_wready <= !next_w_held;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(aw_q) ? ucf_pkg::RESP_OKAY : ucf_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_status_a <= ucf_pkg::CTRL_A_RST;
      ctrl_status_b <= ucf_pkg::CTRL_B_RST;
      ctrl_status_c <= ucf_pkg::CTRL_C_RST;
      baud_divisor <= ucf_pkg::BAUD_RST;
      reload <= 1'b0;
    end else begin
      reload <= wr_lane && aw_q == ucf_pkg::OFS_BAUD_LO;
      if (wr_lane) begin
        if (aw_q == ucf_pkg::OFS_CTRL_A) begin
          ctrl_status_a <= w_q[7:0];
        end else if (aw_q == ucf_pkg::OFS_CTRL_B) begin
          ctrl_status_b <= w_q[7:0];
        end else if (aw_q == ucf_pkg::OFS_CTRL_C) begin
          ctrl_status_c <= w_q[7:0];
        end else if (aw_q == ucf_pkg::OFS_BAUD_LO) begin
          baud_divisor[7:0] <= w_q[7:0];
        end else if (aw_q == ucf_pkg::OFS_BAUD_HI) begin
          baud_divisor[11:8] <= w_q[3:0];
        end
      end
    end
  end

  // a write that alters size, parity or stop select aborts both directions
  assign fmt_change = wr_lane && ((aw_q == ucf_pkg::OFS_CTRL_B
    && w_q[ucf_pkg::B_CSZ2] != ctrl_status_b[ucf_pkg::B_CSZ2])
    || (aw_q == ucf_pkg::OFS_CTRL_C && w_q[5:1] != ctrl_status_c[5:1]));

  assign bif.divisor = baud_divisor;
  assign bif.reload = reload;
  assign bif.xck_pin = sync_clock_pin_i;

  // mode and format decode
  assign sync_mode_select = ctrl_status_c[ucf_pkg::C_SYNC];
  assign master = ctrl_status_b[ucf_pkg::B_PINDIR];
  assign dbl = ctrl_status_a[ucf_pkg::A_DSPEED] && !sync_mode_select;
  assign nbits = ucf_pkg::char_bits({ctrl_status_b[ucf_pkg::B_CSZ2],
    ctrl_status_c[ucf_pkg::C_CSZ_LO+1:ucf_pkg::C_CSZ_LO]});
  assign par_en = ctrl_status_c[ucf_pkg::C_PAR_LO+1];
  assign par_odd = ctrl_status_c[ucf_pkg::C_PAR_LO];
  assign pol = ctrl_status_c[ucf_pkg::C_POL];
  assign os_div = dbl ? ucf_pkg::OS_DOUBLE : ucf_pkg::OS_NORMAL;
  assign os_last = 4'(os_div - 5'h01);
  assign os_half = 4'((os_div >> 1) - 5'h01);

  // transfer clock pin: driven only as sync master
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_clock_pin_o <= 1'b0;
      sync_clock_pin_oe <= 1'b0;
    end else begin
      sync_clock_pin_oe <= sync_mode_select && master;
      if (sync_mode_select && master) begin
        if (bif.tick) begin
          sync_clock_pin_o <= ~sync_clock_pin_o;
        end
      end else begin
        sync_clock_pin_o <= 1'b0;
      end
    end
  end

  // external edges are used only in slave mode; the slave relies on xck below fosc/4
  assign ck_rise = sync_mode_select && (master ? (bif.tick && !sync_clock_pin_o)
    : bif.xck_rise);
  assign ck_fall = sync_mode_select && (master ? (bif.tick && sync_clock_pin_o)
    : bif.xck_fall);
  assign chg_edge = pol ? ck_fall : ck_rise;
  assign smp_edge = pol ? ck_rise : ck_fall;

  // transmit bit enable
  always_ff @(posedge aclk) begin
    if (!aresetn || sync_mode_select) begin
      tx_pre <= 4'h0;
    end else if (bif.tick) begin
      tx_pre <= (tx_pre == os_last) ? 4'h0 : tx_pre + 4'h1;
    end
  end

  assign tx_bit = sync_mode_select ? chg_edge : (bif.tick && tx_pre == os_last);
  assign tx_load = wr_lane && aw_q == ucf_pkg::OFS_TX_DATA
    && tx_state == ucf_pkg::TX_IDLE && !fmt_change;
  assign exp_par = ucf_pkg::par_bit(tx_word, nbits, par_odd);

  // transmitter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_state <= ucf_pkg::TX_IDLE;
      txd <= 1'b1;
      tx_sh <= 9'h000;
      tx_word <= 9'h000;
      tx_cnt <= 4'h0;
      tx_par <= 1'b0;
    end else if (fmt_change) begin
      tx_state <= ucf_pkg::TX_IDLE;
      txd <= 1'b1;
    end else if (tx_load) begin
      tx_state <= ucf_pkg::TX_START;
      tx_sh <= {ctrl_status_b[ucf_pkg::B_NINTH], w_q[7:0]};
      tx_word <= {ctrl_status_b[ucf_pkg::B_NINTH], w_q[7:0]};
      tx_par <= ucf_pkg::par_bit({ctrl_status_b[ucf_pkg::B_NINTH], w_q[7:0]},
        nbits, par_odd);
      tx_cnt <= 4'h0;
    end else if (tx_bit) begin
      case (tx_state)
        ucf_pkg::TX_IDLE: begin
          txd <= 1'b1;
        end
        ucf_pkg::TX_START: begin
          txd <= 1'b0;
          tx_state <= ucf_pkg::TX_DATA;
        end
        ucf_pkg::TX_DATA: begin
          txd <= tx_sh[0];
          tx_sh <= tx_sh >> 1;
          tx_cnt <= tx_cnt + 4'h1;
          if (tx_cnt == nbits - 4'h1) begin
            tx_state <= par_en ? ucf_pkg::TX_PAR : ucf_pkg::TX_STOP1;
          end
        end
        ucf_pkg::TX_PAR: begin
          txd <= tx_par;
          tx_state <= ucf_pkg::TX_STOP1;
        end
        ucf_pkg::TX_STOP1: begin
          txd <= 1'b1;
          tx_state <= ctrl_status_c[ucf_pkg::C_STOP] ? ucf_pkg::TX_STOP2 : ucf_pkg::TX_IDLE;
        end
        ucf_pkg::TX_STOP2: begin
          txd <= 1'b1;
          tx_state <= ucf_pkg::TX_IDLE;
        end
        default: begin
          tx_state <= ucf_pkg::TX_IDLE;
        end
      endcase
    end
  end

  // receive line synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= rxd;
      rx_s2 <= rx_s1;
    end
  end

  // recovery sample counter on undivided ticks
  always_ff @(posedge aclk) begin
    if (!aresetn || sync_mode_select || rx_state == ucf_pkg::RX_IDLE) begin
      rx_os <= 4'h0;
    end else if (bif.tick) begin
      rx_os <= (rx_os == ((rx_state == ucf_pkg::RX_START) ? os_half : os_last))
        ? 4'h0 : rx_os + 4'h1;
    end
  end

  assign rx_mid = !sync_mode_select && bif.tick && rx_state == ucf_pkg::RX_START
    && rx_os == os_half;
  assign rx_step = sync_mode_select ? smp_edge : (bif.tick && rx_os == os_last);
  assign rx_fin = rx_state == ucf_pkg::RX_STOP && rx_step && !fmt_change;

  // receiver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state <= ucf_pkg::RX_IDLE;
      rx_cnt <= 4'h0;
      rx_sh <= 9'h000;
      rx_acc <= 1'b0;
    end else if (fmt_change) begin
      rx_state <= ucf_pkg::RX_IDLE;
    end else begin
      case (rx_state)
        ucf_pkg::RX_IDLE: begin
          if (!rx_s2 && (sync_mode_select ? smp_edge : bif.tick)) begin
            rx_state <= sync_mode_select ? ucf_pkg::RX_DATA : ucf_pkg::RX_START;
            rx_cnt <= 4'h0;
            rx_acc <= par_odd;
          end
        end
        ucf_pkg::RX_START: begin
          if (rx_mid) begin
            rx_state <= rx_s2 ? ucf_pkg::RX_IDLE : ucf_pkg::RX_DATA;
          end
        end
        ucf_pkg::RX_DATA: begin
          if (rx_step) begin
            rx_sh <= {rx_s2, rx_sh[8:1]};
            rx_acc <= rx_acc ^ rx_s2;
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == nbits - 4'h1) begin
              rx_state <= par_en ? ucf_pkg::RX_PAR : ucf_pkg::RX_STOP;
            end
          end
        end
        ucf_pkg::RX_PAR: begin
          if (rx_step) begin
            rx_acc <= rx_acc ^ rx_s2;
            rx_state <= ucf_pkg::RX_STOP;
          end
        end
        ucf_pkg::RX_STOP: begin
          if (rx_step) begin
            rx_state <= ucf_pkg::RX_IDLE;
          end
        end
        default: begin
          rx_state <= ucf_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // receive result and flags; a new frame wins over a clearing read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_data <= 9'h000;
      rx_done <= 1'b0;
      frame_error_flag <= 1'b0;
      parity_error <= 1'b0;
    end else if (rx_fin) begin
      rx_data <= rx_sh >> (4'h9 - nbits);
      rx_done <= 1'b1;
      frame_error_flag <= !rx_s2;
      parity_error <= par_en && rx_acc;
    end else if (rd_rx) begin
      rx_done <= 1'b0;
      frame_error_flag <= 1'b0;
      parity_error <= 1'b0;
    end
  end

  // axi4-lite read channel
  always_comb begin
    rd_ok = 1'b1;
    if (s_axi_araddr == ucf_pkg::OFS_CTRL_A) begin
      rd_word = {24'h000000, ctrl_status_a};
    end else if (s_axi_araddr == ucf_pkg::OFS_CTRL_B) begin
      rd_word = {24'h000000, ctrl_status_b};
    end else if (s_axi_araddr == ucf_pkg::OFS_CTRL_C) begin
      rd_word = {24'h000000, ctrl_status_c};
    end else if (s_axi_araddr == ucf_pkg::OFS_BAUD_LO) begin
      rd_word = {24'h000000, baud_divisor[7:0]};
    end else if (s_axi_araddr == ucf_pkg::OFS_BAUD_HI) begin
      rd_word = {28'h0000000, baud_divisor[11:8]};
    end else if (s_axi_araddr == ucf_pkg::OFS_RX_DATA) begin
      rd_word = {23'h000000, rx_data};
    end else if (s_axi_araddr == ucf_pkg::OFS_STATUS) begin
      rd_word = {28'h0000000, parity_error, frame_error_flag, rx_done,
        tx_state != ucf_pkg::TX_IDLE};
    end else begin
      rd_word = 32'h0000_0000;
      rd_ok = addr_ok(s_axi_araddr);
    end
  end

  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_rx = rd_take && s_axi_araddr == ucf_pkg::OFS_RX_DATA;
  assign next_rvalid = (s_axi_rvalid && !s_axi_rready) || rd_take;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ucf_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (rd_take) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? ucf_pkg::RESP_OKAY : ucf_pkg::RESP_SLVERR;
      end
    end
  end

  property p_pin_master;
    @(posedge aclk) disable iff (!aresetn)
    (sync_mode_select && master) |=> sync_clock_pin_oe;
  endproperty
  a_pin_master: assert property (p_pin_master) else $error("master does not drive clock");

  property p_pin_async;
    @(posedge aclk) disable iff (!aresetn)
    !sync_mode_select |=> !sync_clock_pin_oe && !sync_clock_pin_o;
  endproperty
  a_pin_async: assert property (p_pin_async) else $error("clock pin used in async");

  property p_bit_div;
    @(posedge aclk) disable iff (!aresetn)
    (tx_bit && !sync_mode_select) |-> tx_pre == (dbl ? 4'h7 : 4'hf);
  endproperty
  a_bit_div: assert property (p_bit_div) else $error("async bit divisor wrong");

  property p_edges;
    @(posedge aclk) disable iff (!aresetn)
    (sync_mode_select && master && $past(sync_mode_select && master) && !$past(fmt_change)
      && $changed(txd)) |-> ($past(pol) ? $fell(sync_clock_pin_o) : $rose(sync_clock_pin_o));
  endproperty
  a_edges: assert property (p_edges) else $error("change and sample edges wrong");

  property p_idle_high;
    @(posedge aclk) disable iff (!aresetn)
    tx_state == ucf_pkg::TX_IDLE |-> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not high when idle");

  property p_start_low;
    @(posedge aclk) disable iff (!aresetn)
    (tx_bit && tx_state == ucf_pkg::TX_START && !fmt_change)
      |=> !txd && tx_state == ucf_pkg::TX_DATA;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_parity;
    @(posedge aclk) disable iff (!aresetn)
    (tx_bit && tx_state == ucf_pkg::TX_PAR && !fmt_change) |=> txd == $past(exp_par);
  endproperty
  a_parity: assert property (p_parity) else $error("parity bit wrong");

  property p_frame_err;
    @(posedge aclk) disable iff (!aresetn)
    rx_fin |=> frame_error_flag != $past(rx_s2);
  endproperty
  a_frame_err: assert property (p_frame_err) else $error("frame error wrong");

  property p_par_mode;
    @(posedge aclk) disable iff (!aresetn)
    tx_state == ucf_pkg::TX_PAR |-> ctrl_status_c[ucf_pkg::C_PAR_LO+1];
  endproperty
  a_par_mode: assert property (p_par_mode) else $error("parity sent while disabled");

  property p_abort;
    @(posedge aclk) disable iff (!aresetn)
    fmt_change |=> tx_state == ucf_pkg::TX_IDLE && rx_state == ucf_pkg::RX_IDLE && txd;
  endproperty
  a_abort: assert property (p_abort) else $error("format change did not abort");
endmodule

// ### testbench/ucf_peer.sv
// remote serial receiver that samples the block's transmit line
`timescale 1ns/1ps
module ucf_peer (
  input wire logic aclk,
  input wire logic line,
  input wire logic [7:0] bitp,
  output logic [11:0] frame,
  output logic got
);
  initial begin
    got = 1'b0;
    frame = 12'h000;
    forever begin
      @(negedge line);
      got = 1'b0;
      repeat (bitp / 2) @(posedge aclk);
      for (int i = 0; i < 12; i++) begin
        frame[i] = line;
        repeat (bitp) @(posedge aclk);
      end
      got = 1'b1;
    end
  end
endmodule

// ### testbench/ucf_top_tb.sv
// self-checking bench for the serial clock and frame block
`timescale 1ns/1ps
module ucf_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sync_clock_pin_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, bitp = 8'h10;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic txd, rxd, sync_clock_pin_o, sync_clock_pin_oe, got;
  logic xck_run = 1'b0;
  logic [11:0] frame;
  int mismatches = 0, cmp_count = 0;
  assign rxd = txd;
  always #5 aclk = ~aclk;
  always begin
    repeat (4) @(posedge aclk);
    if (xck_run) sync_clock_pin_i <= ~sync_clock_pin_i;
  end
  ucf_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .txd(txd), .rxd(rxd), .sync_clock_pin_i(sync_clock_pin_i),
    .sync_clock_pin_o(sync_clock_pin_o), .sync_clock_pin_oe(sync_clock_pin_oe));
  ucf_peer u_peer (.aclk(aclk), .line(txd), .bitp(bitp), .frame(frame), .got(got));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask
  task automatic send(input logic [7:0] d, input logic [7:0] bp, input logic [11:0] e);
    bitp = bp;
    wr(ucf_pkg::OFS_TX_DATA, d, ucf_pkg::RESP_OKAY);
    for (int i = 0; i < 3000 && got; i++) @(posedge aclk);
    for (int i = 0; i < 3000 && !got; i++) @(posedge aclk);
    chk(32'(frame), 32'(e));
  endtask
  task automatic t_regs();
    rd(ucf_pkg::OFS_CTRL_C, 32'(ucf_pkg::CTRL_C_RST), ucf_pkg::RESP_OKAY);
    rd(8'h20, 32'h0, ucf_pkg::RESP_SLVERR);
    wr(8'h24, 8'h55, ucf_pkg::RESP_SLVERR);
  endtask
  task automatic t_async();
    send(8'ha5, 8'd16, 12'hf4a);
    chk(32'(sync_clock_pin_oe), 32'h0);
    wr(ucf_pkg::OFS_CTRL_A, 8'h02, ucf_pkg::RESP_OKAY);
    send(8'h0f, 8'd8, 12'he1e);
    wr(ucf_pkg::OFS_CTRL_A, 8'h00, ucf_pkg::RESP_OKAY);
    wr(ucf_pkg::OFS_BAUD_LO, 8'h01, ucf_pkg::RESP_OKAY);
    send(8'h5a, 8'd32, 12'heb4);
    wr(ucf_pkg::OFS_BAUD_LO, 8'h00, ucf_pkg::RESP_OKAY);
  endtask
  task automatic t_format();
    wr(ucf_pkg::OFS_CTRL_C, 8'h34, ucf_pkg::RESP_OKAY);
    send(8'h35, 8'd16, 12'hf6a);
    rd(ucf_pkg::OFS_STATUS, 32'h2, ucf_pkg::RESP_OKAY);
    rd(ucf_pkg::OFS_RX_DATA, 32'h35, ucf_pkg::RESP_OKAY);
    wr(ucf_pkg::OFS_CTRL_C, 8'h26, ucf_pkg::RESP_OKAY);
    send(8'h35, 8'd16, 12'hc6a);
    wr(ucf_pkg::OFS_CTRL_C, 8'h08, ucf_pkg::RESP_OKAY);
    send(8'h13, 8'd16, 12'hfe6);
    wr(ucf_pkg::OFS_CTRL_B, 8'h05, ucf_pkg::RESP_OKAY);
    wr(ucf_pkg::OFS_CTRL_C, 8'h06, ucf_pkg::RESP_OKAY);
    send(8'h80, 8'd16, 12'hf00);
  endtask
  task automatic t_sync();
    logic p;
    wr(ucf_pkg::OFS_BAUD_LO, 8'h03, ucf_pkg::RESP_OKAY);
    wr(ucf_pkg::OFS_CTRL_B, 8'h80, ucf_pkg::RESP_OKAY);
    wr(ucf_pkg::OFS_CTRL_C, 8'h46, ucf_pkg::RESP_OKAY);
    send(8'hc3, 8'd8, 12'hf86);
    chk(32'(sync_clock_pin_oe), 32'h1);
    p = sync_clock_pin_o;
    repeat (4) @(posedge aclk);
    chk(32'(sync_clock_pin_o), 32'(!p));
    rd(ucf_pkg::OFS_RX_DATA, 32'hc3, ucf_pkg::RESP_OKAY);
    wr(ucf_pkg::OFS_CTRL_B, 8'h00, ucf_pkg::RESP_OKAY);
    wr(ucf_pkg::OFS_CTRL_C, 8'h47, ucf_pkg::RESP_OKAY);
    xck_run <= 1'b1;
    send(8'h3c, 8'd8, 12'he78);
    xck_run <= 1'b0;
    chk(32'(sync_clock_pin_oe), 32'h0);
    rd(ucf_pkg::OFS_RX_DATA, 32'h3c, ucf_pkg::RESP_OKAY);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_async();
    t_format();
    t_sync();
    final_report();
  end
  initial begin
    repeat (30000) @(posedge aclk);
    mismatches++;
    final_report();
  end
endmodule
